// ### rtl/dmrb_map.vh
// Purpose: offsets, field positions and reset values of the mode register bank
// Assumes: 6-bit register index, 8-bit operand
// Notes:   definitions only
`ifndef DMRB_MAP_VH
`define DMRB_MAP_VH
// ---------------------------------------------------------------
// register indices
// ---------------------------------------------------------------
`define DMRB_IDX_DEVICE_INFO   6'h00
`define DMRB_IDX_BURST_PRE     6'h01
`define DMRB_IDX_LATENCY       6'h02
`define DMRB_IDX_IO_CFG1       6'h03
`define DMRB_IDX_REFRESH_TRN   6'h04
`define DMRB_IDX_MAKER         6'h05
`define DMRB_IDX_REV1          6'h06
`define DMRB_IDX_REV2          6'h07
`define DMRB_IDX_WIDTH_DENS    6'h08
`define DMRB_IDX_TEST_MODE     6'h09
`define DMRB_IDX_ZQ_CAL        6'h0a
`define DMRB_IDX_TERM          6'h0b
`define DMRB_IDX_CA_VREF       6'h0c
`define DMRB_IDX_REG_CTRL      6'h0d
`define DMRB_IDX_DQ_VREF       6'h0e
`define DMRB_IDX_LB_INV        6'h0f
`define DMRB_IDX_BANK_MASK     6'h10
`define DMRB_IDX_SEG_MASK      6'h11
`define DMRB_IDX_OSC_LOW       6'h12
`define DMRB_IDX_OSC_HIGH      6'h13
`define DMRB_IDX_HB_INV        6'h14
`define DMRB_IDX_VENDOR_USE    6'h15
`define DMRB_IDX_TERM2         6'h16
`define DMRB_IDX_OSC_RUNTIME   6'h17
`define DMRB_IDX_ROW_HAMMER    6'h18
`define DMRB_IDX_REPAIR_RES    6'h19
`define DMRB_IDX_TEST_A        6'h1e
`define DMRB_IDX_CAL_PAT_A     6'h20
`define DMRB_IDX_TEST_B        6'h27
`define DMRB_IDX_CAL_PAT_B     6'h28
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DMRB_BIT_WR_SP         6
`define DMRB_BIT_OP_SP         7
`define DMRB_BIT_REPAIR_PROT   2
`define DMRB_BIT_REPAIR_ENTRY  4
// ---------------------------------------------------------------
// reserved-bit masks: one marks a defined operand bit
// ---------------------------------------------------------------
`define DMRB_MASK_DEVICE_INFO  8'h9b
`define DMRB_MASK_ZQ_CAL       8'h01
`define DMRB_MASK_TERM         8'h77
`define DMRB_MASK_VREF         8'h7f
`define DMRB_MASK_FULL         8'hff
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define DMRB_RST_ZERO          8'h00
`define DMRB_RST_VREF          8'h4d
`define DMRB_RST_IO_CFG1       8'h31
`endif

// ### rtl/dmrb_access_class.v
// Purpose: decodes the access class of a register index
// Assumes: index from the command decoder on the same clock
// Notes:   combinational; reserved and unused indices are neither
`timescale 1ns/1ps
`include "dmrb_map.vh"
module dmrb_access_class (
  input  wire [5:0] register_index_i, // register selected
  output reg        readable_o,       // read returns stored data
  output reg        writable_o,       // write updates storage
  output reg  [7:0] rsvd_mask_o       // ones mark defined bits
);
  always @* begin
    readable_o  = 1'b0;
    writable_o  = 1'b0;
    rsvd_mask_o = `DMRB_MASK_FULL;
    case (register_index_i)
      `DMRB_IDX_DEVICE_INFO: begin
        readable_o  = 1'b1;
        rsvd_mask_o = `DMRB_MASK_DEVICE_INFO;
      end
      `DMRB_IDX_MAKER, `DMRB_IDX_REV1, `DMRB_IDX_REV2,
      `DMRB_IDX_WIDTH_DENS, `DMRB_IDX_OSC_LOW, `DMRB_IDX_OSC_HIGH,
      `DMRB_IDX_REPAIR_RES:
        readable_o = 1'b1;
      `DMRB_IDX_REFRESH_TRN, `DMRB_IDX_ROW_HAMMER: begin
        readable_o = 1'b1;
        writable_o = 1'b1;
      end
      `DMRB_IDX_CA_VREF, `DMRB_IDX_DQ_VREF: begin
        readable_o  = 1'b1;
        writable_o  = 1'b1;
        rsvd_mask_o = `DMRB_MASK_VREF;
      end
      `DMRB_IDX_ZQ_CAL: begin
        writable_o  = 1'b1;
        rsvd_mask_o = `DMRB_MASK_ZQ_CAL;
      end
      `DMRB_IDX_TERM: begin
        writable_o  = 1'b1;
        rsvd_mask_o = `DMRB_MASK_TERM;
      end
      `DMRB_IDX_BURST_PRE, `DMRB_IDX_LATENCY, `DMRB_IDX_IO_CFG1,
      `DMRB_IDX_TEST_MODE, `DMRB_IDX_REG_CTRL, `DMRB_IDX_LB_INV,
      `DMRB_IDX_BANK_MASK, `DMRB_IDX_SEG_MASK, `DMRB_IDX_HB_INV,
      `DMRB_IDX_VENDOR_USE, `DMRB_IDX_TERM2, `DMRB_IDX_OSC_RUNTIME,
      `DMRB_IDX_CAL_PAT_A, `DMRB_IDX_CAL_PAT_B:
        writable_o = 1'b1;
      default: begin
        readable_o = 1'b0;
        writable_o = 1'b0;
      end
    endcase
  end
endmodule

// ### rtl/dmrb_set_point_pair.v
// Purpose: two set-point copies of one duplicated mode register
// Assumes: write strobe already qualified by address and access
// Notes:   write and read go to the write copy, operation uses the op copy
`timescale 1ns/1ps
module dmrb_set_point_pair #(
  parameter [7:0] RST_VAL = 8'h00  // reset value of both copies
) (
  input  wire       clk_i,         // command clock
  input  wire       rst_n_i,       // async reset, active low
  input  wire       wr_en_i,       // store operand this cycle
  input  wire [7:0] wr_data_i,     // operand to store
  input  wire       wr_sel_i,      // write set point select
  input  wire       op_sel_i,      // operating set point select
  output wire [7:0] rd_data_o,     // copy seen by reads
  output wire [7:0] active_o       // copy driving operation
);
  reg [7:0] copy0_r;
  reg [7:0] copy1_r;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      copy0_r <= RST_VAL;
      copy1_r <= RST_VAL;
    end else if (wr_en_i) begin
      if (wr_sel_i) begin
        copy1_r <= wr_data_i;
      end else begin
        copy0_r <= wr_data_i;
      end
    end
  end
  assign rd_data_o = wr_sel_i ? copy1_r : copy0_r;
  assign active_o  = op_sel_i ? copy1_r : copy0_r;
endmodule

// ### rtl/dmrb_mode_reg_bank.v
// Purpose: mode register bank answering register reads and writes
// Assumes: commands arrive decoded, on clk_i, one per cycle at most
// Notes:   read data registered, valid one cycle after the command
//
// Overview of operation
// - read returns eight operand bits of register picked by six-bit index
// - write stores the supplied operand into the addressed writable register; test mode and vendor use keep nothing, calibration only pulses zq_reset_o
// - every register is read-only, write-only or read-write, honoured so
// - reads return zero in every reserved operand bit
// - reads of reserved or write-only registers return zero
// - writes to read-only registers change nothing
// - duplicated registers are written and read at the write set point copy
// - operation uses the operating set point copy; other copy is ignored
// - repair protection, once set, stays set until power-on reset
// - while protected, writes setting repair entry are refused
`timescale 1ns/1ps
`include "dmrb_map.vh"
module dmrb_mode_reg_bank #(
  parameter [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter [7:0] REV_ONE    = 8'h01, // arbitrary value
  parameter [7:0] REV_TWO    = 8'h00, // arbitrary value
  parameter [7:0] WIDTH_DENS = 8'h00, // device width and density
  parameter [7:0] DEV_INFO   = 8'h00, // device info straps
  parameter [7:0] REPAIR_RES = 8'h00  // repair resource map
) (
  input  wire       clk_i,            // command clock
  input  wire       rst_n_i,          // async reset, active low
  input  wire       mrr_i,            // read command, one cycle
  input  wire       mrw_i,            // write command, one cycle
  input  wire [5:0] register_index_i, // register selected
  input  wire [7:0] operand_bits_i,   // write operand
  input  wire [7:0] osc_count_i,      // strobe oscillator count source
  input  wire       osc_high_i,       // count source is high byte
  output reg  [7:0] operand_bits_o,   // read data
  output reg        rd_valid_o,       // read data valid, one cycle
  output wire [7:0] burst_cfg_o,      // active burst/preamble setting
  output wire [7:0] latency_cfg_o,    // active latency setting
  output wire [7:0] io_cfg_o,         // active io configuration
  output wire [7:0] term_cfg_o,       // active termination setting
  output wire [7:0] ca_vref_o,        // active command vref
  output wire [7:0] dq_vref_o,        // active data vref
  output wire [7:0] term2_cfg_o,      // active termination feature two
  output wire [7:0] reg_ctrl_o,       // register control value
  output wire [7:0] refresh_ctrl_o,   // refresh and training control
  output wire       repair_protect_o, // repair protection state
  output wire       zq_reset_o,       // calibration reset request
  output wire [7:0] bank_mask_o,      // partial refresh bank mask
  output wire [7:0] seg_mask_o,       // partial refresh segment mask
  output wire [7:0] lb_invert_o,      // low byte invert pattern
  output wire [7:0] hb_invert_o,      // high byte invert pattern
  output wire [7:0] osc_runtime_o,    // oscillator runtime
  output wire [7:0] row_hammer_o,     // row hammer control
  output wire [7:0] cal_pat_a_o,      // calibration pattern a
  output wire [7:0] cal_pat_b_o       // calibration pattern b
);
  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  wire       readable;
  wire       writable;
  wire [7:0] rsvd_mask;
  dmrb_access_class u_class (
    .register_index_i (register_index_i),
    .readable_o       (readable),
    .writable_o       (writable),
    .rsvd_mask_o      (rsvd_mask)
  );
  wire       wr_ok   = mrw_i & writable;
  wire [7:0] wr_data = operand_bits_i & rsvd_mask;

  // ---------------------------------------------------------------
  // register control and single-copy storage
  // ---------------------------------------------------------------
  reg  [7:0] reg_ctrl_r;
  reg  [7:0] refresh_r;
  reg        repair_prot_r;
  reg  [7:0] bank_mask_r;
  reg  [7:0] seg_mask_r;
  reg  [7:0] lb_inv_r;
  reg  [7:0] hb_inv_r;
  reg  [7:0] osc_rt_r;
  reg  [7:0] row_ham_r;
  reg  [7:0] pat_a_r;
  reg  [7:0] pat_b_r;
  reg  [7:0] osc_low_r;
  reg  [7:0] osc_high_r;
  reg        zq_rst_r;
  wire wr_sel = reg_ctrl_r[`DMRB_BIT_WR_SP];
  wire op_sel = reg_ctrl_r[`DMRB_BIT_OP_SP];
  wire hit_refresh = wr_ok &
                     (register_index_i == `DMRB_IDX_REFRESH_TRN);
  wire entry_refused = repair_prot_r &
                       wr_data[`DMRB_BIT_REPAIR_ENTRY];

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_ctrl_r    <= `DMRB_RST_ZERO;
      refresh_r     <= `DMRB_RST_ZERO;
      repair_prot_r <= 1'b0;
      bank_mask_r   <= `DMRB_RST_ZERO;
      seg_mask_r    <= `DMRB_RST_ZERO;
      lb_inv_r      <= `DMRB_RST_ZERO;
      hb_inv_r      <= `DMRB_RST_ZERO;
      osc_rt_r      <= `DMRB_RST_ZERO;
      row_ham_r     <= `DMRB_RST_ZERO;
      pat_a_r       <= `DMRB_RST_ZERO;
      pat_b_r       <= `DMRB_RST_ZERO;
      zq_rst_r      <= 1'b0;
    end else begin
      zq_rst_r <= 1'b0;
      if (hit_refresh && !entry_refused) begin
        refresh_r <= wr_data;
      end
      if (wr_ok && register_index_i == `DMRB_IDX_IO_CFG1 &&
          wr_data[`DMRB_BIT_REPAIR_PROT]) begin
        repair_prot_r <= 1'b1;
      end
      if (wr_ok) begin
        case (register_index_i)
          `DMRB_IDX_REG_CTRL:    reg_ctrl_r  <= wr_data;
          `DMRB_IDX_BANK_MASK:   bank_mask_r <= wr_data;
          `DMRB_IDX_SEG_MASK:    seg_mask_r  <= wr_data;
          `DMRB_IDX_LB_INV:      lb_inv_r    <= wr_data;
          `DMRB_IDX_HB_INV:      hb_inv_r    <= wr_data;
          `DMRB_IDX_OSC_RUNTIME: osc_rt_r    <= wr_data;
          `DMRB_IDX_ROW_HAMMER:  row_ham_r   <= wr_data;
          `DMRB_IDX_CAL_PAT_A:   pat_a_r     <= wr_data;
          `DMRB_IDX_CAL_PAT_B:   pat_b_r     <= wr_data;
          `DMRB_IDX_ZQ_CAL:      zq_rst_r    <= wr_data[0];
          default:               zq_rst_r    <= 1'b0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // oscillator count capture, read-only to the controller
  // ---------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_low_r  <= `DMRB_RST_ZERO;
      osc_high_r <= `DMRB_RST_ZERO;
    end else if (osc_high_i) begin
      osc_high_r <= osc_count_i;
    end else begin
      osc_low_r  <= osc_count_i;
    end
  end

  // ---------------------------------------------------------------
  // set-point duplicated registers
  // ---------------------------------------------------------------
  localparam NSP = 7;
  // constants, so that the reset values can be handed down as parameters
  localparam [NSP*6-1:0] sp_idx = {`DMRB_IDX_TERM2, `DMRB_IDX_DQ_VREF,
                                   `DMRB_IDX_CA_VREF, `DMRB_IDX_TERM,
                                   `DMRB_IDX_IO_CFG1, `DMRB_IDX_LATENCY,
                                   `DMRB_IDX_BURST_PRE};
  localparam [NSP*8-1:0] sp_rst = {`DMRB_RST_ZERO, `DMRB_RST_VREF,
                                   `DMRB_RST_VREF, `DMRB_RST_ZERO,
                                   `DMRB_RST_IO_CFG1, `DMRB_RST_ZERO,
                                   `DMRB_RST_ZERO};
  wire [NSP*8-1:0] sp_rd;
  wire [NSP*8-1:0] sp_act;
  genvar g;
  generate
    for (g = 0; g < NSP; g = g + 1) begin : g_sp
      dmrb_set_point_pair #(
        .RST_VAL (sp_rst[g*8 +: 8])
      ) u_pair (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .wr_en_i   (wr_ok && register_index_i == sp_idx[g*6 +: 6]),
        .wr_data_i (wr_data),
        .wr_sel_i  (wr_sel),
        .op_sel_i  (op_sel),
        .rd_data_o (sp_rd[g*8 +: 8]),
        .active_o  (sp_act[g*8 +: 8])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  reg [7:0] rd_nxt;
  always @* begin
    case (register_index_i)
      `DMRB_IDX_DEVICE_INFO: rd_nxt = DEV_INFO;
      `DMRB_IDX_REFRESH_TRN: rd_nxt = refresh_r;
      `DMRB_IDX_MAKER:       rd_nxt = MAKER_CODE;
      `DMRB_IDX_REV1:        rd_nxt = REV_ONE;
      `DMRB_IDX_REV2:        rd_nxt = REV_TWO;
      `DMRB_IDX_WIDTH_DENS:  rd_nxt = WIDTH_DENS;
      `DMRB_IDX_CA_VREF:     rd_nxt = sp_rd[4*8 +: 8];
      `DMRB_IDX_DQ_VREF:     rd_nxt = sp_rd[5*8 +: 8];
      `DMRB_IDX_OSC_LOW:     rd_nxt = osc_low_r;
      `DMRB_IDX_OSC_HIGH:    rd_nxt = osc_high_r;
      `DMRB_IDX_ROW_HAMMER:  rd_nxt = row_ham_r;
      `DMRB_IDX_REPAIR_RES:  rd_nxt = REPAIR_RES;
      default:               rd_nxt = 8'h00;
    endcase
    if (!readable) begin
      rd_nxt = 8'h00;
    end
    rd_nxt = rd_nxt & rsvd_mask;
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      operand_bits_o <= 8'h00;
      rd_valid_o     <= 1'b0;
    end else begin
      rd_valid_o <= mrr_i;
      if (mrr_i) begin
        operand_bits_o <= rd_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // operating values
  // ---------------------------------------------------------------
  assign burst_cfg_o      = sp_act[0*8 +: 8];
  assign latency_cfg_o    = sp_act[1*8 +: 8];
  assign io_cfg_o         = {sp_act[2*8+3 +: 5], repair_prot_r,
                             sp_act[2*8 +: 2]};
  assign term_cfg_o       = sp_act[3*8 +: 8];
  assign ca_vref_o        = sp_act[4*8 +: 8];
  assign dq_vref_o        = sp_act[5*8 +: 8];
  assign term2_cfg_o      = sp_act[6*8 +: 8];
  assign reg_ctrl_o       = reg_ctrl_r;
  assign refresh_ctrl_o   = refresh_r;
  assign repair_protect_o = repair_prot_r;
  assign zq_reset_o       = zq_rst_r;
  assign bank_mask_o      = bank_mask_r;
  assign seg_mask_o       = seg_mask_r;
  assign lb_invert_o      = lb_inv_r;
  assign hb_invert_o      = hb_inv_r;
  assign osc_runtime_o    = osc_rt_r;
  assign row_hammer_o     = row_ham_r;
  assign cal_pat_a_o      = pat_a_r;
  assign cal_pat_b_o      = pat_b_r;
endmodule

// ### tb/dmrb_bank_sva.sv
// Purpose: port checks of the mode register bank
// Assumes: one command per cycle, read data one edge later
// Notes:   bound to the bank below the module
`timescale 1ns/1ps
module dmrb_bank_sva #(
  parameter [7:0] MAKER_CODE = 8'h5a  // arbitrary value
) (
  input wire       clk_i,            // command clock
  input wire       rst_n_i,          // async reset, active low
  input wire       mrr_i,            // read command
  input wire       mrw_i,            // write command
  input wire [5:0] register_index_i, // register selected
  input wire [7:0] operand_bits_i,   // write operand
  input wire [7:0] operand_bits_o,   // read data
  input wire       rd_valid_o,       // read data valid
  input wire [7:0] refresh_ctrl_o,   // refresh control
  input wire [7:0] row_hammer_o,     // row hammer control
  input wire [7:0] dq_vref_o,        // active data vref
  input wire       repair_protect_o, // repair protection
  input wire       zq_reset_o        // calibration reset
);
  wire [5:0]  idx = register_index_i;
  wire [24:0] state = {refresh_ctrl_o, row_hammer_o, dq_vref_o,
                       repair_protect_o};
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  read_answer_a: assert property (mrr_i |=> rd_valid_o)
    else $error("read not answered next cycle");
  no_stray_a: assert property (!mrr_i |=> !rd_valid_o)
    else $error("read valid without a read");
  ro_read_a: assert property (mrr_i && idx == 6'h05
    |=> operand_bits_o == MAKER_CODE) else $error("read-only data wrong");
  wo_read_a: assert property (mrr_i && idx == 6'h01
    |=> operand_bits_o == 8'h00) else $error("write-only read not zero");
  rsvd_bits_a: assert property (mrr_i && (idx == 6'h0c || idx == 6'h0e)
    |=> !operand_bits_o[7]) else $error("reserved bit read as one");
  ro_write_a: assert property (mrw_i && idx == 6'h05
    |=> $stable(state) && !zq_reset_o) else $error("read-only write acted");
  rsvd_write_a: assert property (mrw_i && (idx == 6'h1e || idx == 6'h21
    || idx == 6'h27) |=> $stable(state)) else $error("ignored write acted");
  sticky_prot_a: assert property (repair_protect_o |=> repair_protect_o)
    else $error("repair protection cleared");
  entry_block_a: assert property (repair_protect_o && mrw_i && idx == 6'h04
    && operand_bits_i[4] |=> $stable(refresh_ctrl_o))
    else $error("repair entry write accepted");
  rw_store_a: assert property (mrw_i && idx == 6'h18
    |=> row_hammer_o == $past(operand_bits_i)) else $error("write not stored");
  zq_pulse_a: assert property (mrw_i && idx == 6'h0a && operand_bits_i[0]
    |=> zq_reset_o) else $error("calibration reset missing");
endmodule
bind dmrb_mode_reg_bank dmrb_bank_sva #(.MAKER_CODE(MAKER_CODE)) u_dmrb_bank_sva (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .mrr_i(mrr_i), .mrw_i(mrw_i),
  .register_index_i(register_index_i), .operand_bits_i(operand_bits_i),
  .operand_bits_o(operand_bits_o), .rd_valid_o(rd_valid_o),
  .refresh_ctrl_o(refresh_ctrl_o), .row_hammer_o(row_hammer_o),
  .dq_vref_o(dq_vref_o), .repair_protect_o(repair_protect_o),
  .zq_reset_o(zq_reset_o));

// ### tb/dmrb_ctrl_model.sv
// Purpose: controller issuing mode register reads and writes
// Assumes: tasks entered at a falling clock edge
// Notes:   gap adds idle cycles before each command
`timescale 1ns/1ps
module dmrb_ctrl_model (
  input  wire       clk_i,            // command clock
  input  wire       rd_valid_i,       // read data valid
  input  wire [7:0] rd_data_i,        // read data
  output reg        mrr_o,            // read command
  output reg        mrw_o,            // write command
  output reg  [5:0] register_index_o, // register selected
  output reg  [7:0] operand_bits_o    // write operand
);
  integer gap = 0;
  integer miss = 0;
  initial begin
    mrr_o = 1'b0;
    mrw_o = 1'b0;
    register_index_o = 6'h00;
    operand_bits_o = 8'h00;
  end
  // ones mark defined operand bits
  function [7:0] rfu_mask(input [5:0] idx);
    case (idx)
      6'h0a: rfu_mask = 8'h01;
      6'h0b: rfu_mask = 8'h77;
      6'h0c, 6'h0e: rfu_mask = 8'h7f;
      default: rfu_mask = 8'hff;
    endcase
  endfunction
  task automatic write_reg(input [5:0] idx, input [7:0] data);
    begin
      repeat (gap) @(negedge clk_i);
      if ((idx < 6'h1a || idx > 6'h1d) && idx != 6'h1f && idx < 6'h30) begin
        mrw_o = 1'b1;
        register_index_o = idx;
        operand_bits_o = data & rfu_mask(idx);
        @(negedge clk_i);
        mrw_o = 1'b0;
        register_index_o = ~idx;
        operand_bits_o = ~operand_bits_o;
        @(negedge clk_i);
      end
    end
  endtask
  task automatic read_reg(input [5:0] idx, output [7:0] data);
    integer k;
    begin
      repeat (gap) @(negedge clk_i);
      mrr_o = 1'b1;
      register_index_o = idx;
      @(negedge clk_i);
      mrr_o = 1'b0;
      register_index_o = ~idx;
      k = 0;
      while (rd_valid_i !== 1'b1 && k < 4) begin
        @(negedge clk_i);
        k = k + 1;
      end
      if (rd_valid_i !== 1'b1)
        miss = miss + 1;
      data = rd_data_i;
      @(negedge clk_i);
    end
  endtask
endmodule

// ### tb/dram_mode_register_bank_tb.sv
// Purpose: self-checking bench of the mode register bank
// Assumes: bank answers reads one edge after the command
// Notes:   read-only contents set by parameters below
`timescale 1ns/1ps
module dram_mode_register_bank_tb;
  localparam [7:0] MAKER = 8'h5a; // arbitrary value
  localparam [7:0] REV1  = 8'h3c; // arbitrary value
  localparam [7:0] REV2  = 8'h0f; // arbitrary value
  localparam [7:0] WD    = 8'ha6;
  localparam [7:0] RES   = 8'h81;
  reg        clk_i;
  reg        rst_n_i;
  reg  [7:0] osc_count_i;
  reg        osc_high_i;
  reg  [7:0] got;
  wire       mrr, mrw, rd_valid, repair_protect, zq_reset;
  wire [5:0] idx;
  wire [7:0] opw, rdata, dq_vref, ca_vref, io_cfg, refresh_ctrl;
  wire [7:0] bank_mask, pat_b, term2, reg_ctrl;
  integer    bad_count = 0;
  integer    n_compared = 0;
  dmrb_ctrl_model u_dmrb_ctrl_model (.clk_i(clk_i), .rd_valid_i(rd_valid),
    .rd_data_i(rdata), .mrr_o(mrr), .mrw_o(mrw), .register_index_o(idx),
    .operand_bits_o(opw));
  dmrb_mode_reg_bank #(.MAKER_CODE(MAKER), .REV_ONE(REV1), .REV_TWO(REV2),
    .WIDTH_DENS(WD), .DEV_INFO(8'hff), .REPAIR_RES(RES)) u_dmrb_mode_reg_bank (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mrr_i(mrr), .mrw_i(mrw),
    .register_index_i(idx), .operand_bits_i(opw), .osc_count_i(osc_count_i),
    .osc_high_i(osc_high_i), .operand_bits_o(rdata), .rd_valid_o(rd_valid),
    .burst_cfg_o(), .latency_cfg_o(), .io_cfg_o(io_cfg), .term_cfg_o(),
    .ca_vref_o(ca_vref), .dq_vref_o(dq_vref), .term2_cfg_o(term2),
    .reg_ctrl_o(reg_ctrl),
    .refresh_ctrl_o(refresh_ctrl), .repair_protect_o(repair_protect),
    .zq_reset_o(zq_reset), .bank_mask_o(bank_mask), .seg_mask_o(),
    .lb_invert_o(),
    .hb_invert_o(), .osc_runtime_o(), .row_hammer_o(), .cal_pat_a_o(),
    .cal_pat_b_o(pat_b));
  task check(input [7:0] act, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (act !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
      end
    end
  endtask
  task rd(input [5:0] a, input [7:0] exp);
    begin
      u_dmrb_ctrl_model.read_reg(a, got);
      check(got, exp);
    end
  endtask
  task wr(input [5:0] a, input [7:0] d);
    u_dmrb_ctrl_model.write_reg(a, d);
  endtask
  task tally_and_finish;
    begin
      bad_count = bad_count + u_dmrb_ctrl_model.miss;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    bad_count = bad_count + 1;
    tally_and_finish;
  end
  initial begin
    rst_n_i = 1'b0;
    osc_count_i = 8'h00;
    osc_high_i = 1'b0;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    check(dq_vref, 8'h4d);
    check(io_cfg, 8'h31);
    rd(6'h00, 8'h9b);
    rd(6'h05, MAKER);
    rd(6'h06, REV1);
    rd(6'h07, REV2);
    rd(6'h08, WD);
    rd(6'h19, RES);
    wr(6'h05, 8'ha5);
    rd(6'h05, MAKER);
    wr(6'h01, 8'h5a);
    rd(6'h01, 8'h00);
    rd(6'h1f, 8'h00);
    wr(6'h18, 8'h81);
    rd(6'h18, 8'h81);
    wr(6'h1e, 8'h7e);
    wr(6'h21, 8'h42);
    wr(6'h27, 8'h18);
    rd(6'h18, 8'h81);
    wr(6'h0c, 8'hff);
    rd(6'h0c, 8'h7f);
    check(ca_vref, 8'h7f);
    u_dmrb_ctrl_model.gap = 2;
    wr(6'h0d, 8'h40);
    wr(6'h0e, 8'h22);
    check(dq_vref, 8'h4d);
    rd(6'h0e, 8'h22);
    wr(6'h0d, 8'hc0);
    check(reg_ctrl, 8'hc0);
    check(dq_vref, 8'h22);
    wr(6'h0d, 8'h00);
    rd(6'h0e, 8'h4d);
    u_dmrb_ctrl_model.gap = 0;
    osc_count_i = 8'h3b;
    @(negedge clk_i);
    rd(6'h12, 8'h3b);
    osc_high_i = 1'b1;
    osc_count_i = 8'hc4;
    @(negedge clk_i);
    rd(6'h13, 8'hc4);
    rd(6'h12, 8'h3b);
    wr(6'h0a, 8'h01);
    wr(6'h04, 8'h05);
    rd(6'h04, 8'h05);
    wr(6'h03, 8'h04);
    check({7'h00, repair_protect}, 8'h01);
    wr(6'h03, 8'h00);
    check({7'h00, repair_protect}, 8'h01);
    wr(6'h04, 8'h10);
    rd(6'h04, 8'h05);
    check(refresh_ctrl, 8'h05);
    wr(6'h10, 8'h3c);
    check(bank_mask, 8'h3c);
    wr(6'h28, 8'h96);
    check(pat_b, 8'h96);
    wr(6'h16, 8'h5c);
    check(term2, 8'h5c);
    check(reg_ctrl, 8'h00);
    tally_and_finish;
  end
endmodule
